// *** cpu_side_model.sv ***
// Purpose: processor side that takes the single interrupt request
// Assumes: request and status are registered on clk_i
// Notes:   latches level and vector on each rising request
`timescale 1ns/1ps
module cpu_side_model (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       irq_req_i,
    input  wire logic [3:0] level_i,
    input  wire logic [6:0] vector_i,
    output logic      [3:0] taken_level_o,
    output logic      [6:0] taken_vector_o,
    output logic      [7:0] taken_cnt_o
);
    logic irq_d_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_d_r        <= 1'b0;
            taken_level_o  <= 4'h0;
            taken_vector_o <= 7'h00;
            taken_cnt_o    <= 8'h00;
        end else begin
            irq_d_r <= irq_req_i;
            if (irq_req_i && !irq_d_r) begin
                taken_level_o  <= level_i;
                taken_vector_o <= vector_i;
                taken_cnt_o    <= taken_cnt_o + 8'h01;
            end
        end
    end
endmodule : cpu_side_model

// *** interrupt_priority_config.sv ***
// Purpose: priority fields, arbiter and pending status of an interrupt controller
// Assumes: flags and enables arrive from same-clock logic; avalon-mm slave, 16-bit data
// Notes:   every access takes one wait cycle; unmapped reads return zero
`timescale 1ns/1ps
`include "intprio_regs.svh"

// Functional notes
// - three-bit priority, 7 highest, 1 lowest
// - priority zero disables the source entirely
// - unimplemented bits read zero, ignore writes
// - capture8 14-12, capture7 10-8, extint1 2-0
// - extint2 priority in bits 6-4 only
// - encoder 10-8, pwm one 6-4
// - pwm one fault in bits 14-12
// - pwm two fault 10-8, pwm two 6-4
// - status level bits 11-8, resets zero
// - status vector bits 6-0, vector minus eight
// - all priority fields reset to four
// - equal priority: lower vector address wins
module interrupt_priority_config #(
    parameter int          NUM_SOURCES = 10,
    parameter logic [6:0]  VEC_EXTINT1 = 7'h0C,
    parameter logic [6:0]  VEC_CAPTURE7 = 7'h0D,
    parameter logic [6:0]  VEC_CAPTURE8 = 7'h0E,
    parameter logic [6:0]  VEC_EXTINT2 = 7'h0F,
    parameter logic [6:0]  VEC_ENCODER = 7'h10,
    parameter logic [6:0]  VEC_PWM_ONE = 7'h11,
    parameter logic [6:0]  VEC_PWM_ONE_FAULT = 7'h12,
    parameter logic [6:0]  VEC_PWM_TWO = 7'h13,
    parameter logic [6:0]  VEC_PWM_TWO_FAULT = 7'h14,
    parameter logic [6:0]  VEC_UART_ONE_ERROR = 7'h15
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic [7:0]             avs_address_i,
    input  wire logic                   avs_read_i,
    input  wire logic                   avs_write_i,
    input  wire logic [15:0]            avs_writedata_i,
    output logic      [15:0]            avs_readdata_o,
    output logic                        avs_waitrequest_o,
    input  wire logic [NUM_SOURCES-1:0] flag_i,
    input  wire logic [NUM_SOURCES-1:0] enable_i,
    output logic                        irq_req_o,
    output logic      [3:0]             new_cpu_level_o,
    output logic      [6:0]             pending_vector_index_o
);

    // ****************************************
    // priority storage
    // ****************************************
    logic [2:0] prio_r [NUM_SOURCES];
    logic [3:0] cpu_level_r;
    intprio_pkg::status_type status_r;
    intprio_pkg::status_type status_nxt;
    logic       irq_r;
    logic       irq_nxt;
    logic       ack_r;
    logic [15:0] rdata_r;

    // ****************************************
    // bus decode
    // ****************************************
    intprio_pkg::bus_req_type req;
    assign req = '{avs_read_i, avs_write_i, avs_address_i, avs_writedata_i};

    wire access_go = (req.read | req.write) & ~ack_r;
    // writes land at the answering edge, while waitrequest is low
    wire wr_go     = req.write & ack_r;
    wire sel_cap   = (req.address == `CAPTURE_EXTINT1_PRIORITY_IDX);
    wire sel_ext2  = (req.address == `EXTINT2_PRIORITY_IDX);
    wire sel_enc   = (req.address == `ENCODER_PWM1_PRIORITY_IDX);
    wire sel_flt1  = (req.address == `PWM1_FAULT_PRIORITY_IDX);
    wire sel_uart  = (req.address == `UART_ERROR_PRIORITY_IDX);
    wire sel_pwm2  = (req.address == `PWM2_PRIORITY_IDX);
    wire sel_stat  = (req.address == `PENDING_INTERRUPT_STATUS_IDX);
    wire sel_lvl   = (req.address == `CURRENT_LEVEL_IDX);

    wire [15:0] rd_cap  = {1'b0, prio_r[intprio_pkg::SRC_CAPTURE8], 1'b0,
                           prio_r[intprio_pkg::SRC_CAPTURE7], 5'h00,
                           prio_r[intprio_pkg::SRC_EXTINT1]};
    wire [15:0] rd_ext2 = {9'h000, prio_r[intprio_pkg::SRC_EXTINT2], 4'h0};
    wire [15:0] rd_enc  = {5'h00, prio_r[intprio_pkg::SRC_ENCODER], 1'b0,
                           prio_r[intprio_pkg::SRC_PWM_ONE], 4'h0};
    wire [15:0] rd_flt1 = {1'b0, prio_r[intprio_pkg::SRC_PWM_ONE_FAULT], 12'h000};
    wire [15:0] rd_uart = {9'h000, prio_r[intprio_pkg::SRC_UART_ONE_ERROR], 4'h0};
    wire [15:0] rd_pwm2 = {5'h00, prio_r[intprio_pkg::SRC_PWM_TWO_FAULT], 1'b0,
                           prio_r[intprio_pkg::SRC_PWM_TWO], 4'h0};
    wire [15:0] rd_stat = {4'h0, status_r.level, 1'b0, status_r.vector_index};

    wire [15:0] rd_mux =
        sel_cap  ? rd_cap  :
        sel_ext2 ? rd_ext2 :
        sel_enc  ? rd_enc  :
        sel_flt1 ? rd_flt1 :
        sel_uart ? rd_uart :
        sel_pwm2 ? rd_pwm2 :
        sel_stat ? rd_stat :
        sel_lvl  ? {12'h000, cpu_level_r} : 16'h0000;

    // ****************************************
    // bus handshake: one wait cycle
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            ack_r   <= access_go;
            rdata_r <= (access_go & req.read) ? rd_mux : rdata_r;
        end
    end

    // waitrequest high unless the answer stands this cycle
    logic wait_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~access_go;
        end
    end

    // ****************************************
    // priority field writes
    // ****************************************
    function automatic logic [2:0] pick(input logic [15:0] d, input int pos);
        pick = d[pos +: 3];
    endfunction : pick

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NUM_SOURCES; i++) begin
                prio_r[i] <= `PRIO_RESET_LEVEL;
            end
            cpu_level_r <= 4'h0;
        end else if (wr_go) begin
            if (sel_cap) begin
                prio_r[intprio_pkg::SRC_CAPTURE8] <= pick(req.writedata, `CAPTURE8_PRIO_POS);
                prio_r[intprio_pkg::SRC_CAPTURE7] <= pick(req.writedata, `CAPTURE7_PRIO_POS);
                prio_r[intprio_pkg::SRC_EXTINT1]  <= pick(req.writedata, `EXTINT1_PRIO_POS);
            end else if (sel_ext2) begin
                prio_r[intprio_pkg::SRC_EXTINT2] <= pick(req.writedata, `EXTINT2_PRIO_POS);
            end else if (sel_enc) begin
                prio_r[intprio_pkg::SRC_ENCODER] <= pick(req.writedata, `ENCODER_PRIO_POS);
                prio_r[intprio_pkg::SRC_PWM_ONE] <= pick(req.writedata, `PWM_ONE_PRIO_POS);
            end else if (sel_flt1) begin
                prio_r[intprio_pkg::SRC_PWM_ONE_FAULT] <=
                    pick(req.writedata, `PWM_ONE_FAULT_PRIO_POS);
            end else if (sel_uart) begin
                prio_r[intprio_pkg::SRC_UART_ONE_ERROR] <=
                    pick(req.writedata, `UART_ONE_ERROR_PRIO_POS);
            end else if (sel_pwm2) begin
                prio_r[intprio_pkg::SRC_PWM_TWO_FAULT] <=
                    pick(req.writedata, `PWM_TWO_FAULT_PRIO_POS);
                prio_r[intprio_pkg::SRC_PWM_TWO] <= pick(req.writedata, `PWM_TWO_PRIO_POS);
            end else if (sel_lvl) begin
                cpu_level_r <= req.writedata[3:0];
            end
        end
    end

    // ****************************************
    // arbiter
    // ****************************************
    logic [6:0] vec_tab [NUM_SOURCES];
    assign vec_tab = '{VEC_EXTINT1, VEC_CAPTURE7, VEC_CAPTURE8, VEC_EXTINT2,
                       VEC_ENCODER, VEC_PWM_ONE, VEC_PWM_ONE_FAULT, VEC_PWM_TWO,
                       VEC_PWM_TWO_FAULT, VEC_UART_ONE_ERROR};

    logic [2:0] best_prio;
    logic [6:0] best_vec;
    logic       found;

    always_comb begin
        best_prio = 3'h0;
        best_vec  = 7'h00;
        found     = 1'b0;
        for (int i = 0; i < NUM_SOURCES; i++) begin
            // strict compare keeps lower vector on ties
            if (flag_i[i] && enable_i[i] && (prio_r[i] != 3'h0)
                && (prio_r[i] > best_prio)) begin
                best_prio = prio_r[i];
                best_vec  = vec_tab[i];
                found     = 1'b1;
            end
        end
    end

    wire win = found && ({1'b0, best_prio} > cpu_level_r);
    wire [6:0] vec_minus = 7'(best_vec - 7'(`VECTOR_BASE));

    always_comb begin
        status_nxt = status_r;
        irq_nxt    = win;
        if (win) begin
            status_nxt.level        = {1'b0, best_prio};
            status_nxt.vector_index = vec_minus;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_r <= '0;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign avs_readdata_o         = rdata_r;
    assign avs_waitrequest_o      = wait_r;
    assign irq_req_o              = irq_r;
    assign new_cpu_level_o        = status_r.level;
    assign pending_vector_index_o = status_r.vector_index;

    // ****************************************
    // checks
    // ****************************************
    sequence req_taken;
        access_go;
    endsequence

    sequence cap_write;
        wr_go && sel_cap;
    endsequence

    sequence enc_write;
        wr_go && sel_enc;
    endsequence

    sequence pwm2_write;
        wr_go && sel_pwm2;
    endsequence

    // bit positions that hold no field
    wire [15:0] hole_mask =
        sel_cap               ? 16'h88F8 :
        (sel_ext2 | sel_uart) ? 16'hFF8F :
        (sel_enc | sel_pwm2)  ? 16'hF88F :
        sel_flt1              ? 16'h8FFF :
        sel_stat              ? 16'hF080 :
        sel_lvl               ? 16'hFFF0 : 16'hFFFF;

    // every field still at its reset level
    logic prio_all_reset;
    always_comb begin
        prio_all_reset = 1'b1;
        for (int i = 0; i < NUM_SOURCES; i++) begin
            if (prio_r[i] != `PRIO_RESET_LEVEL) begin
                prio_all_reset = 1'b0;
            end
        end
    end

    chk_zero_disables: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        irq_r |-> $past(found)) else $error("request without valid source");

    chk_above_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        irq_r |-> ($past(cpu_level_r) < status_r.level)) else $error("level not above cpu");

    chk_status_track: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        win |=> (status_r.vector_index == $past(vec_minus)))
        else $error("vector index not updated");

    chk_status_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !win |=> $stable(status_r)) else $error("status changed without winner");

    chk_answer_one: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        req_taken |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer timing wrong");

    chk_unused_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ack_r && req.read && sel_flt1) |-> (avs_readdata_o[11:0] == 12'h000))
        else $error("unimplemented bits not zero");

    chk_holes_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ack_r && req.read) |-> ((avs_readdata_o & hole_mask) == 16'h0000))
        else $error("unused read bits not zero");

    chk_ext2_field: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_go && sel_ext2) |=> (prio_r[intprio_pkg::SRC_EXTINT2] == $past(req.writedata[6:4])))
        else $error("extint2 field not written");

    chk_cap8_field: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_go && sel_cap) |=>
            (prio_r[intprio_pkg::SRC_CAPTURE8] == $past(req.writedata[14:12])))
        else $error("capture8 field not written");

    chk_cap_low_fields: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cap_write |=>
            (prio_r[intprio_pkg::SRC_CAPTURE7] == $past(req.writedata[10:8]))
            && (prio_r[intprio_pkg::SRC_EXTINT1] == $past(req.writedata[2:0])))
        else $error("capture7 or extint1 field not written");

    chk_enc_fields: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        enc_write |=>
            (prio_r[intprio_pkg::SRC_ENCODER] == $past(req.writedata[10:8]))
            && (prio_r[intprio_pkg::SRC_PWM_ONE] == $past(req.writedata[6:4])))
        else $error("encoder or pwm one field not written");

    chk_flt1_field: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_go && sel_flt1) |=>
            (prio_r[intprio_pkg::SRC_PWM_ONE_FAULT] == $past(req.writedata[14:12])))
        else $error("pwm one fault field not written");

    chk_uart_field: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_go && sel_uart) |=>
            (prio_r[intprio_pkg::SRC_UART_ONE_ERROR] == $past(req.writedata[6:4])))
        else $error("uart one error field not written");

    chk_pwm2_fields: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        pwm2_write |=>
            (prio_r[intprio_pkg::SRC_PWM_TWO_FAULT] == $past(req.writedata[10:8]))
            && (prio_r[intprio_pkg::SRC_PWM_TWO] == $past(req.writedata[6:4])))
        else $error("pwm two fields not written");

    chk_level_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        irq_r |-> (status_r.level != 4'h0 && status_r.level <= 4'h7))
        else $error("level out of range");

    // fields come out of reset at four
    chk_reset_four: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !$past(rst_b_i) |-> (prio_all_reset && (status_r == '0)))
        else $error("reset levels wrong");

endmodule : interrupt_priority_config

// *** interrupt_priority_config_test.sv ***
// Purpose: self-checking bench of the priority block
// Assumes: one wait cycle per bus access, arbiter answers one edge later
// Notes:   flags and enables are driven by the bench
`timescale 1ns/1ps
`include "intprio_regs.svh"
module interrupt_priority_config_test;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [15:0] avs_writedata_i = 16'h0000;
    logic [15:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [9:0]  flag_i = 10'h000;
    logic [9:0]  enable_i = 10'h3FF;
    logic        irq_req_o;
    logic [3:0]  new_cpu_level_o;
    logic [6:0]  pending_vector_index_o;
    logic [3:0]  tk_level;
    logic [6:0]  tk_vec;
    logic [7:0]  tk_cnt;
    logic [15:0] rd;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;
    logic [7:0]  idx [6] = '{8'hAE, 8'hB2, 8'hC0, 8'hC2, 8'hC4, 8'hC8};
    logic [15:0] rstv [6] = '{16'h4404, 16'h0040, 16'h0440, 16'h4000, 16'h0040, 16'h0440};
    logic [15:0] msk [6] = '{16'h7707, 16'h0070, 16'h0770, 16'h7000, 16'h0070, 16'h0770};
    localparam logic [6:0] V7 = 7'h0D;
    localparam logic [6:0] V8 = 7'h0E;

    always #4 clk_i = ~clk_i;

    interrupt_priority_config #(
        .VEC_CAPTURE7(V7),
        .VEC_CAPTURE8(V8)
    ) interrupt_priority_config_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .flag_i(flag_i), .enable_i(enable_i),
        .irq_req_o(irq_req_o), .new_cpu_level_o(new_cpu_level_o),
        .pending_vector_index_o(pending_vector_index_o));

    cpu_side_model cpu_side_model_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .irq_req_i(irq_req_o),
        .level_i(new_cpu_level_o), .vector_i(pending_vector_index_o),
        .taken_level_o(tk_level), .taken_vector_o(tk_vec), .taken_cnt_o(tk_cnt));

    task automatic close_out();
        $display("compares %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        // wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus

    task automatic arb(input logic [9:0] f, input logic ei, input logic [3:0] lv,
                       input logic [6:0] v);
        @(posedge clk_i);
        flag_i <= f;
        repeat (3) @(posedge clk_i);
        check("irq", {15'h0, irq_req_o}, {15'h0, ei});
        if (ei) begin
            bus(1'b0, `PENDING_INTERRUPT_STATUS_IDX, 16'h0, rd);
            check("status", rd, {4'h0, lv, 1'b0, v});
            check("level port", {12'h0, new_cpu_level_o}, {12'h0, lv});
            check("vector port", {9'h0, pending_vector_index_o}, {9'h0, v});
        end
    endtask : arb

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        bus(1'b0, `PENDING_INTERRUPT_STATUS_IDX, 16'h0, rd);
        check("status reset", rd, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, idx[i], 16'h0, rd);
            check("prio reset", rd, rstv[i]);
        end
        // software reaches priorities only through the register port
        bus(1'b1, `CAPTURE_EXTINT1_PRIORITY_IDX, 16'h5500, rd);
        arb(10'h001, 1'b0, 4'h0, 7'h00);
        arb(10'h007, 1'b1, 4'h5, V7 - 7'h08);
        check("taken vector", {9'h0, tk_vec}, {9'h0, V7 - 7'h08});
        bus(1'b1, `CAPTURE_EXTINT1_PRIORITY_IDX, 16'h7100, rd);
        arb(10'h3FF, 1'b1, 4'h7, V8 - 7'h08);
        bus(1'b1, `CURRENT_LEVEL_IDX, 16'h0007, rd);
        arb(10'h3FF, 1'b0, 4'h0, 7'h00);
        bus(1'b1, `CURRENT_LEVEL_IDX, 16'h0004, rd);
        arb(10'h002, 1'b0, 4'h0, 7'h00);
        arb(10'h004, 1'b1, 4'h7, V8 - 7'h08);
        bus(1'b1, `CURRENT_LEVEL_IDX, 16'h0000, rd);
        enable_i <= 10'h3FB;
        arb(10'h006, 1'b1, 4'h1, V7 - 7'h08);
        enable_i <= 10'h3FF;
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, idx[i], 16'hFFFF, rd);
            bus(1'b0, idx[i], 16'h0, rd);
            check("prio mask", rd, msk[i]);
            bus(1'b1, idx[i], 16'h0000, rd);
        end
        arb(10'h3FF, 1'b0, 4'h0, 7'h00);
        bus(1'b1, `PENDING_INTERRUPT_STATUS_IDX, 16'hFFFF, rd);
        bus(1'b0, `PENDING_INTERRUPT_STATUS_IDX, 16'h0, rd);
        check("status ro", rd & 16'hF080, 16'h0000);
        bus(1'b0, 8'h10, 16'h0, rd);
        check("unmapped", rd, 16'h0000);
        check("taken count", {8'h0, tk_cnt}, 16'h0004);
        close_out();
    end
endmodule : interrupt_priority_config_test

// *** intprio_pkg.sv ***
// Purpose: types shared by the priority block
// Assumes: ten peripheral sources in natural vector order
// Notes:   constants live in intprio_regs.svh
package intprio_pkg;

    // sources in ascending vector-table order (lower index wins a tie)
    typedef enum logic [3:0] {
        SRC_EXTINT1,
        SRC_CAPTURE7,
        SRC_CAPTURE8,
        SRC_EXTINT2,
        SRC_ENCODER,
        SRC_PWM_ONE,
        SRC_PWM_ONE_FAULT,
        SRC_PWM_TWO,
        SRC_PWM_TWO_FAULT,
        SRC_UART_ONE_ERROR
    } source_type;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [15:0] writedata;
    } bus_req_type;

    typedef struct packed {
        logic [3:0] level;
        logic [6:0] vector_index;
    } status_type;

endpackage : intprio_pkg

// *** intprio_regs.svh ***
// Purpose: offsets, field positions, reset values and timing for the priority block
// Assumes: avalon-mm word addressing, byte address = 2 * index
// Notes:   definitions only
`ifndef INTPRIO_REGS_SVH
`define INTPRIO_REGS_SVH

// register indices (byte address is two times the index)
`define CAPTURE_EXTINT1_PRIORITY_IDX 8'hAE
`define EXTINT2_PRIORITY_IDX         8'hB2
`define ENCODER_PWM1_PRIORITY_IDX    8'hC0
`define PWM1_FAULT_PRIORITY_IDX      8'hC2
`define UART_ERROR_PRIORITY_IDX      8'hC4
`define PWM2_PRIORITY_IDX            8'hC8
`define PENDING_INTERRUPT_STATUS_IDX 8'hE0
`define CURRENT_LEVEL_IDX            8'hE2

// field low-bit positions
`define CAPTURE8_PRIO_POS      12
`define CAPTURE7_PRIO_POS      8
`define EXTINT1_PRIO_POS       0
`define EXTINT2_PRIO_POS       4
`define ENCODER_PRIO_POS       8
`define PWM_ONE_PRIO_POS       4
`define PWM_ONE_FAULT_PRIO_POS 12
`define UART_ONE_ERROR_PRIO_POS 4
`define PWM_TWO_FAULT_PRIO_POS 8
`define PWM_TWO_PRIO_POS       4
`define NEW_CPU_LEVEL_POS      8
`define PENDING_VECTOR_POS     0

// reset values
`define PRIO_RESET_LEVEL       3'h4
`define STATUS_RESET           16'h0000

// vector number offset of the pending vector field
`define VECTOR_BASE            8'h08

// bus answer latency: one wait cycle, answer on the next edge
`define BUS_WAIT_CYCLES        1

`endif
